// file: flash_ctrl.sv
// Flash access controller: array decode, sector mapping, register window, busy lock.
// Assumes the CPU end keeps its own bus rules; the array is a small behavioural store.
//
// Overview of operation
// - 32-bit fetch words, 16-bit register reads
// - Bus writes only reach the register area
// - Decode array, reserved hole, register space
// - One 256K bank, eight sectors, test sector
// - Normal map: sectors 0-3 low, rest high
// - Alternate map: test sector low in bootstrap only, 0-3 to segment 1
// - Bootstrap fetches show test sector at zero
// - Host programs low addresses from segment 1 in bootstrap only
// - Bootstrap entry clears segment-1 remap
// - Operation registers at 08'0000h to 08'0015h
// - Byte and halfword register access
// - Unprotect register on peripheral bus
// - Decode protection registers and mirror
// - Host sets map enable before access
// - Busy array reads give invalid, trap
// - Host runs write code outside flash
// - Host uses indirect register writes
// - Host holds register writes from start until an idle cycle
// - Supply drop aborts write, back to read
// - Power-down instruction switches module off
// - Host holds power-down from start until an idle cycle
// - Start sets lock; locked register reads invalid except REG_CR0L
// - Busy clears at end or suspend
`timescale 1ns/1ps
module flash_ctrl (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // CPU side
  flash_bus_if.flash BUS,
  // Status
  output logic BUSY,
  output logic LOCKED,
  output logic POWERED
);
  import flash_pkg::*;

  localparam int MEM_WORDS = 64;
  logic [31:0] mem [MEM_WORDS];
  logic [31:0] test_mem [MEM_WORDS];
  logic [15:0] cr0h, cr1l, cr1h, dr0l, dr0h, dr1l, dr1h, arl, arh, er;
  logic [15:0] nvwp, nvap0, nvap1l, nvap1h, tunprot;
  logic busy, lock, powered, boot_q, eff_remap, remap_q, remap_hold;
  logic [7:0] op_cnt;
  logic [7:0] wake_cnt;
  logic [31:0] rdata;
  logic trap;
  logic [15:0] xrdata;
  logic [23:0] phys;
  logic is_test, in_array, in_regs;
  logic [15:0] reg_val;
  logic reg_hit;

  // Bootstrap entry forces remap low until software raises it again
  always_ff @(posedge CLK) begin
    if (RST) begin
      boot_q <= 1'b0;
      remap_q <= 1'b0;
      remap_hold <= 1'b0;
    end else begin
      boot_q <= BUS.boot;
      remap_q <= BUS.remap;
      if (BUS.boot && !boot_q) remap_hold <= 1'b1;
      else if (!BUS.boot || (BUS.remap && !remap_q)) remap_hold <= 1'b0;
    end
  end
  assign eff_remap = BUS.remap && !remap_hold && !(BUS.boot && !boot_q);

  // Logical to physical mapping; physical space is the normal read layout
  always_comb begin
    is_test = 1'b0;
    phys = BUS.addr;
    in_array = BUS.map_en && (BUS.addr <= FLASH_END);
    if (eff_remap) begin
      if (BUS.addr <= TEST_END) begin
        is_test = BUS.boot;
        in_array = BUS.map_en && BUS.boot;
      end else if (BUS.addr < SEG1_BASE) begin
        in_array = 1'b0;
      end else if (BUS.addr >= SEG1_BASE && BUS.addr <= HOLE_END) begin
        phys = BUS.addr - SEG1_BASE;
      end
    end else if (BUS.addr > LOW32K_END && BUS.addr <= HOLE_END) begin
      in_array = 1'b0;
    end
    // Bootstrap code fetches see the test sector whatever the remap
    if (BUS.boot && BUS.fetch && BUS.addr <= TEST_END) begin
      is_test = 1'b1;
      in_array = BUS.map_en;
    end
    in_regs = BUS.map_en && (BUS.addr >= SVC_BASE) && (BUS.addr <= SVC_END);
  end

  // Register window decode, 16-bit aligned halfwords
  always_comb begin
    reg_hit = 1'b1;
    unique case ({BUS.addr[23:1], 1'b0})
      REG_CR0L: reg_val = {11'h000, lock, 2'b00, busy, 1'b0};
      REG_CR0H: reg_val = cr0h;
      REG_CR1L: reg_val = cr1l;
      REG_CR1H: reg_val = cr1h;
      REG_DR0L: reg_val = dr0l;
      REG_DR0H: reg_val = dr0h;
      REG_DR1L: reg_val = dr1l;
      REG_DR1H: reg_val = dr1h;
      REG_ARL: reg_val = arl;
      REG_ARH: reg_val = arh;
      REG_ER: reg_val = er;
      REG_NVWP, REG_NVWP_MIR: reg_val = nvwp;
      REG_NVAP0: reg_val = nvap0;
      REG_NVAP1L: reg_val = nvap1l;
      REG_NVAP1H: reg_val = nvap1h;
      default: begin
        reg_val = INVALID_HALF;
        reg_hit = 1'b0;
      end
    endcase
  end

  // Byte-lane merge of a register write
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
                                        input logic [1:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  wire reg_wr = BUS.wr && in_regs && reg_hit && !lock && powered;
  wire [23:0] wa = {BUS.addr[23:1], 1'b0};

  always_ff @(posedge CLK) begin
    if (RST) begin
      cr0h <= REG_RESET;
      cr1l <= REG_RESET;
      cr1h <= REG_RESET;
      dr0l <= REG_RESET;
      dr0h <= REG_RESET;
      dr1l <= REG_RESET;
      dr1h <= REG_RESET;
      arl <= REG_RESET;
      arh <= REG_RESET;
      nvwp <= REG_RESET;
      nvap0 <= REG_RESET;
      nvap1l <= REG_RESET;
      nvap1h <= REG_RESET;
    end else if (reg_wr) begin
      unique case (wa)
        REG_CR0H: cr0h <= merge(cr0h, BUS.wdata, BUS.be);
        REG_CR1L: cr1l <= merge(cr1l, BUS.wdata, BUS.be);
        REG_CR1H: cr1h <= merge(cr1h, BUS.wdata, BUS.be);
        REG_DR0L: dr0l <= merge(dr0l, BUS.wdata, BUS.be);
        REG_DR0H: dr0h <= merge(dr0h, BUS.wdata, BUS.be);
        REG_DR1L: dr1l <= merge(dr1l, BUS.wdata, BUS.be);
        REG_DR1H: dr1h <= merge(dr1h, BUS.wdata, BUS.be);
        REG_ARL: arl <= merge(arl, BUS.wdata, BUS.be);
        REG_ARH: arh <= merge(arh, BUS.wdata, BUS.be);
        REG_NVWP, REG_NVWP_MIR: nvwp <= merge(nvwp, BUS.wdata, BUS.be);
        REG_NVAP0: nvap0 <= merge(nvap0, BUS.wdata, BUS.be);
        REG_NVAP1L: nvap1l <= merge(nvap1l, BUS.wdata, BUS.be);
        REG_NVAP1H: nvap1h <= merge(nvap1h, BUS.wdata, BUS.be);
        default: ;
      endcase
    end else if ((busy && op_cnt == 8'd1) || BUS.supply_low || !powered) begin
      cr0h[BIT_START] <= 1'b0;
    end
  end

  // Peripheral-bus unprotect register
  always_ff @(posedge CLK) begin
    if (RST) begin
      tunprot <= REG_RESET;
      xrdata <= REG_RESET;
    end else begin
      if (BUS.xwr && BUS.addr == REG_TUNPROT) tunprot <= BUS.xwdata;
      xrdata <= (BUS.xrd && BUS.addr == REG_TUNPROT) ? tunprot : REG_RESET;
    end
  end

  wire start = reg_wr && wa == REG_CR0H && BUS.be[1] && BUS.wdata[BIT_START];

  // Operation engine: lock and busy with countdown
  always_ff @(posedge CLK) begin
    if (RST) begin
      busy <= 1'b0;
      lock <= 1'b0;
      op_cnt <= 8'd0;
    end else if (BUS.supply_low || !powered) begin
      busy <= 1'b0;
      lock <= 1'b0;
      op_cnt <= 8'd0;
    end else if (start) begin
      busy <= !BUS.wdata[BIT_SUSP];
      lock <= 1'b1;
      op_cnt <= 8'(OP_CYCLES);
    end else if (lock) begin
      busy <= !cr0h[BIT_SUSP] && op_cnt != 8'd0;
      if (!cr0h[BIT_SUSP] && op_cnt != 8'd0) op_cnt <= op_cnt - 8'd1;
      if (op_cnt == 8'd0) lock <= 1'b0;
    end
  end

  // Program commit into the store at the end of an operation
  always_ff @(posedge CLK) begin
    if (RST) begin
      er <= REG_RESET;
      // Both stores come up erased; the bus itself never writes them
      for (int i = 0; i < MEM_WORDS; i++) begin
        mem[i] <= INVALID_WORD;
        test_mem[i] <= INVALID_WORD;
      end
    end else if (busy && op_cnt == 8'd1 && !BUS.supply_low) begin
      mem[arl[7:2]] <= mem[arl[7:2]] & {dr1l, dr0l};
      er <= REG_RESET;
    end
  end

  // Power-down shuts the module, wake waits a recovery count
  always_ff @(posedge CLK) begin
    if (RST) begin
      powered <= 1'b1;
      wake_cnt <= 8'd0;
    end else if (BUS.power_down_instr) begin
      powered <= 1'b0;
      wake_cnt <= 8'(WAKE_CYCLES);
    end else if (!powered) begin
      if (wake_cnt == 8'd0) powered <= 1'b1;
      else wake_cnt <= wake_cnt - 8'd1;
    end
  end

  // Read path: one cycle after the strobe
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata <= 32'h0;
      trap <= 1'b0;
    end else begin
      trap <= 1'b0;
      rdata <= 32'h0;
      if ((BUS.rd || BUS.fetch) && in_array) begin
        if (busy || !powered) begin
          rdata <= INVALID_WORD;
          trap <= 1'b1;
        end else if (is_test) begin
          rdata <= test_mem[phys[7:2]];
        end else begin
          rdata <= mem[phys[7:2]];
        end
      end else if (BUS.rd && in_regs) begin
        if (lock && wa != REG_CR0L) begin
          rdata <= {16'h0000, INVALID_HALF};
          trap <= 1'b1;
        end else begin
          rdata <= {16'h0000, reg_val};
        end
      end
    end
  end

  assign BUS.rdata = rdata;
  assign BUS.trap = trap;
  assign BUS.trap_code = TRAP_CODE;
  assign BUS.xrdata = xrdata;
  assign BUS.flash_ready = powered;
  assign BUSY = busy;
  assign LOCKED = lock;
  assign POWERED = powered;
endmodule

// file: flash_pkg.sv
// Package for the on-chip program memory access controller and its CPU end.
// Assumes one system clock; shared by both ends, the checker and the testbench.
package flash_pkg;
  localparam logic [23:0] FLASH_END = 24'h04ffff;
  localparam logic [23:0] RESV_END = 24'h07ffff;
  localparam logic [23:0] SVC_BASE = 24'h080000;
  localparam logic [23:0] SVC_END = 24'h08ffff;
  localparam logic [23:0] SEG1_BASE = 24'h010000;
  localparam logic [23:0] LOW32K_END = 24'h007fff;
  localparam logic [23:0] HOLE_END = 24'h017fff;
  localparam logic [23:0] TEST_END = 24'h001fff;
  localparam logic [23:0] REG_CR0L = 24'h080000;
  localparam logic [23:0] REG_CR0H = 24'h080002;
  localparam logic [23:0] REG_CR1L = 24'h080004;
  localparam logic [23:0] REG_CR1H = 24'h080006;
  localparam logic [23:0] REG_DR0L = 24'h080008;
  localparam logic [23:0] REG_DR0H = 24'h08000a;
  localparam logic [23:0] REG_DR1L = 24'h08000c;
  localparam logic [23:0] REG_DR1H = 24'h08000e;
  localparam logic [23:0] REG_ARL = 24'h080010;
  localparam logic [23:0] REG_ARH = 24'h080012;
  localparam logic [23:0] REG_ER = 24'h080014;
  localparam logic [23:0] REG_NVWP = 24'h08dfb0;
  localparam logic [23:0] REG_NVWP_MIR = 24'h08dfb4;
  localparam logic [23:0] REG_NVAP0 = 24'h08dfb8;
  localparam logic [23:0] REG_NVAP1L = 24'h08dfbc;
  localparam logic [23:0] REG_NVAP1H = 24'h08dfbe;
  localparam logic [23:0] REG_TUNPROT = 24'h00eb50;
  localparam int BIT_LOCK = 4;
  localparam int BIT_BUSY = 1;
  localparam int BIT_START = 15;
  localparam int BIT_SUSP = 14;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] TRAP_CODE = 16'h009b;
  localparam logic [31:0] INVALID_WORD = 32'hffffffff;
  localparam logic [15:0] INVALID_HALF = 16'hffff;
  localparam int OP_CYCLES = 16;
  localparam int WAKE_CYCLES = 64;
  localparam int HOST_CMD_NONE = 0;
endpackage

// file: flash_bus_if.sv
// Internal CPU bus and peripheral bus between the CPU end and the flash.
// Assumes both ends share CLK; plain synchronous single-cycle strobes.
`timescale 1ns/1ps
interface flash_bus_if;
  logic [23:0] addr;
  logic rd;
  logic wr;
  logic fetch;
  logic [1:0] be;
  logic [15:0] wdata;
  logic [31:0] rdata;
  logic trap;
  logic [15:0] trap_code;
  logic xrd;
  logic xwr;
  logic [15:0] xwdata;
  logic [15:0] xrdata;
  logic map_en;
  logic remap;
  logic boot;
  logic power_down_instr;
  logic supply_low;
  logic flash_ready;
  modport flash (input addr, rd, wr, fetch, be, wdata, xrd, xwr, xwdata, map_en, remap,
    boot, power_down_instr, supply_low, output rdata, trap, trap_code, xrdata, flash_ready);
  modport cpu (output addr, rd, wr, fetch, be, wdata, xrd, xwr, xwdata, map_en, remap,
    boot, power_down_instr, supply_low, input rdata, trap, trap_code, xrdata, flash_ready);
endinterface

// file: flash_cpu.sv
// CPU end: turns user commands into flash bus cycles, keeps host-side rules.
// Assumes the flash end on the same clock and one command at a time.
`timescale 1ns/1ps
module flash_cpu (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // User command port
  input wire logic [23:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic [1:0] BE,
  input wire logic RD,
  input wire logic WR,
  input wire logic FETCH,
  input wire logic XRD,
  input wire logic XWR,
  input wire logic MAP_EN,
  input wire logic REMAP,
  input wire logic BOOT,
  input wire logic POWER_DOWN_INSTR,
  input wire logic SUPPLY_LOW,
  output logic [31:0] RDATA,
  output logic TRAP,
  output logic REFUSED,
  // Flash side
  flash_bus_if.cpu BUS
);
  import flash_pkg::*;

  logic [23:0] addr;
  logic rd, wr, fetch, xrd, xwr, power_down_instr;
  logic [1:0] be;
  logic [15:0] wdata;
  logic refused;
  logic active;

  // Host holds back writes without map enable, and register writes, power-down and fetches from start until an idle cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      active <= 1'b0;
    end else if (WR && ADDR == REG_CR0H && BE[1] && WDATA[BIT_START]) begin
      active <= 1'b1;
    end else if (active && !RD && !WR) begin
      active <= 1'b0;
    end
  end

  wire deny_wr = !MAP_EN || (ADDR >= SVC_BASE && active);
  wire deny_pd = POWER_DOWN_INSTR && active;
  wire deny_fetch = FETCH && active;

  always_ff @(posedge CLK) begin
    if (RST) begin
      addr <= 24'h000000;
      rd <= 1'b0;
      wr <= 1'b0;
      fetch <= 1'b0;
      xrd <= 1'b0;
      xwr <= 1'b0;
      power_down_instr <= 1'b0;
      be <= 2'b00;
      wdata <= 16'h0000;
      refused <= 1'b0;
    end else begin
      addr <= (BOOT && WR && ADDR <= LOW32K_END) ? ADDR + SEG1_BASE : ADDR;
      rd <= RD && MAP_EN;
      wr <= WR && !deny_wr;
      fetch <= FETCH && MAP_EN && !deny_fetch;
      xrd <= XRD;
      xwr <= XWR;
      power_down_instr <= POWER_DOWN_INSTR && !deny_pd;
      be <= BE;
      wdata <= WDATA;
      refused <= (WR && deny_wr) || deny_pd || deny_fetch;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      RDATA <= 32'h0;
      TRAP <= 1'b0;
      REFUSED <= 1'b0;
    end else begin
      RDATA <= BUS.rdata | {16'h0000, BUS.xrdata};
      TRAP <= BUS.trap;
      REFUSED <= refused;
    end
  end

  assign BUS.addr = addr;
  assign BUS.rd = rd;
  assign BUS.wr = wr;
  assign BUS.fetch = fetch;
  assign BUS.be = be;
  assign BUS.wdata = wdata;
  assign BUS.xrd = xrd;
  assign BUS.xwr = xwr;
  assign BUS.xwdata = wdata;
  assign BUS.map_en = MAP_EN;
  assign BUS.remap = REMAP;
  assign BUS.boot = BOOT;
  assign BUS.power_down_instr = power_down_instr;
  assign BUS.supply_low = SUPPLY_LOW;
endmodule

// file: flash_bus_chk_sva.sv
// Concurrent checks on the bus between the CPU end and the flash controller.
// Assumes one clock, RST synchronous active high; instantiated beside the interface.
`timescale 1ns/1ps
module flash_bus_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Bus signals
  input wire logic [23:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic fetch,
  input wire logic [1:0] be,
  input wire logic [15:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic trap,
  input wire logic [15:0] trap_code,
  input wire logic power_down_instr,
  input wire logic supply_low,
  input wire logic flash_ready
);
  import flash_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  trap_cause_a: assert property (trap |-> $past(rd) || $past(fetch))
    else $error("trap without a read or fetch");
  trap_code_a: assert property (trap |-> trap_code == TRAP_CODE)
    else $error("wrong trap code");
  fetch_inv_a: assert property (fetch ##1 trap |-> rdata == INVALID_WORD)
    else $error("trapped fetch not all ones");
  reg_inv_a: assert property ((rd && addr >= SVC_BASE && addr <= SVC_END) ##1 trap
    |-> rdata[15:0] == INVALID_HALF)
    else $error("trapped register read not all ones");
  status_free_a: assert property (rd && addr == REG_CR0L |=> !trap)
    else $error("status register read trapped");
  status_resv_a: assert property (rd && addr == REG_CR0L
    |=> rdata[15:5] == 11'h000 && rdata[3:2] == 2'h0 && !rdata[0])
    else $error("reserved status bits set");
  start_lock_a: assert property ((wr && addr == REG_CR0H && wdata[BIT_START] && be[1]
    && !supply_low) ##1 (rd && addr == REG_CR0L) |=> rdata[BIT_LOCK] && rdata[BIT_BUSY])
    else $error("start did not lock");
  supply_abort_a: assert property (supply_low[*2] ##0 (rd && addr == REG_CR0L)
    |=> !rdata[BIT_BUSY])
    else $error("busy survives supply drop");
  power_down_instr_off_a: assert property (power_down_instr |-> ##[1:4] !flash_ready)
    else $error("module stays on after power-down");
  wake_up_a: assert property ($fell(flash_ready) |-> ##[1:200] flash_ready)
    else $error("module never wakes");
  write_quiet_a: assert property (wr |=> !trap)
    else $error("write answered with trap");
  cover property (fetch ##1 trap);
  cover property (power_down_instr);
  cover property (wr && addr == REG_CR0H && wdata[BIT_START]);
endmodule

// file: tb_top.sv
// Testbench for the flash controller facing its CPU end over the bus interface.
// Assumes CLK at 250 MHz and a synchronous active-high RST held 10 cycles.
`timescale 1ns/1ps
module tb_top;
  import flash_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] addr = 24'h000000;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] be = 2'h3;
  logic rd = 1'b0, wr = 1'b0, fetch = 1'b0, xrd = 1'b0, xwr = 1'b0;
  logic map_en = 1'b1;
  logic remap = 1'b0, boot = 1'b0, power_down_instr = 1'b0, supply_low = 1'b0;
  logic [31:0] rdata;
  logic trap, refused, busy, locked, powered;
  int n_fail = 0;
  int checks = 0;
  always #2 clk = ~clk;
  flash_bus_if bus ();
  flash_ctrl i_flash_ctrl (.CLK(clk), .RST(rst), .BUS(bus), .BUSY(busy), .LOCKED(locked),
    .POWERED(powered));
  flash_cpu i_flash_cpu (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .BE(be), .RD(rd),
    .WR(wr), .FETCH(fetch), .XRD(xrd), .XWR(xwr), .MAP_EN(map_en), .REMAP(remap), .BOOT(boot),
    .POWER_DOWN_INSTR(power_down_instr), .SUPPLY_LOW(supply_low), .RDATA(rdata), .TRAP(trap), .REFUSED(refused),
    .BUS(bus));
  flash_bus_chk i_flash_bus_chk (.CLK(clk), .RST(rst), .addr(bus.addr), .rd(bus.rd),
    .wr(bus.wr), .fetch(bus.fetch), .be(bus.be), .wdata(bus.wdata), .rdata(bus.rdata),
    .trap(bus.trap), .trap_code(bus.trap_code), .power_down_instr(bus.power_down_instr),
    .supply_low(bus.supply_low), .flash_ready(bus.flash_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Kind: 0 read, 1 write, 2 fetch, 3 peripheral read, 4 peripheral write
  task automatic cyc(input int k, input logic [23:0] a, input logic [15:0] d,
    input logic [1:0] b);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd <= (k == 0);
    wr <= (k == 1);
    fetch <= (k == 2);
    xrd <= (k == 3);
    xwr <= (k == 4);
    @(posedge clk);
    {rd, wr, fetch, xrd, xwr} <= 5'h00;
    // Answer stands three cycles after the user strobe
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_for(input int sel, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if ((sel == 0 ? busy : powered) === v) return;
    end
    n_fail++;
    $display("BAD t=%0t wait ran out got=%h exp=%h", $time, ~v, v);
    end_sim();
  endtask
  task automatic t_reset();
    chk({busy, locked, powered}, 32'h1);
    cyc(0, REG_CR0L, 16'h0000, 2'h3);
    chk(rdata[15:0], REG_RESET);
    cyc(0, REG_ER, 16'h0000, 2'h3);
    chk(rdata[15:0], REG_RESET);
    $display("t_reset done");
  endtask
  task automatic t_regs();
    logic [23:0] a;
    for (int i = 0; i < 6; i++) begin
      a = REG_DR0L + 24'(2 * i);
      cyc(1, a, 16'h1234 + 16'(i), 2'h3);
      cyc(0, a, 16'h0000, 2'h3);
      chk(rdata[15:0], 16'h1234 + 16'(i));
    end
    cyc(1, REG_ARH, 16'hbeef, 2'h1);
    cyc(0, REG_ARH, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'h12ef);
    cyc(1, REG_ARH, 16'hbeef, 2'h2);
    cyc(0, REG_ARH, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'hbeef);
    cyc(4, REG_TUNPROT, 16'ha5c3, 2'h3);
    cyc(3, REG_TUNPROT, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'ha5c3);
    $display("t_regs done");
  endtask
  task automatic t_ignore();
    logic [23:0] al [3] = '{24'h000010, 24'h050000, 24'h08f000};
    foreach (al[i]) begin
      cyc(1, al[i], 16'h8000, 2'h3);
      chk(busy, 1'b0);
      cyc(0, REG_CR0L, 16'h0000, 2'h3);
      chk(rdata[15:0], 16'h0000);
    end
    cyc(0, 24'h000010, 16'h0000, 2'h3);
    chk(rdata, INVALID_WORD);
    cyc(0, REG_ARL, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'h1238);
    $display("t_ignore done");
  endtask
  task automatic t_op();
    @(posedge clk);
    addr <= REG_CR0H;
    wdata <= 16'h8000;
    be <= 2'h3;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= REG_CR0L;
    @(posedge clk);
    rd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(rdata[15:0], 16'h0012);
    chk({busy, locked}, 32'h3);
    cyc(2, 24'h000000, 16'h0000, 2'h3);
    chk(rdata, INVALID_WORD);
    chk(trap, 1'b1);
    cyc(0, REG_ARL, 16'h0000, 2'h3);
    chk(rdata[15:0], INVALID_HALF);
    chk(trap, 1'b1);
    wait_for(0, 1'b0, OP_CYCLES + 8);
    chk(locked, 1'b0);
    cyc(0, REG_CR0L, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'h0000);
    $display("t_op done");
  endtask
  task automatic t_supply();
    cyc(1, REG_CR0H, 16'h8000, 2'h3);
    chk(busy, 1'b1);
    @(posedge clk);
    supply_low <= 1'b1;
    wait_for(0, 1'b0, 4);
    cyc(0, REG_CR0L, 16'h0000, 2'h3);
    chk(rdata[BIT_BUSY], 1'b0);
    @(posedge clk);
    supply_low <= 1'b0;
    $display("t_supply done");
  endtask
  task automatic t_refuse();
    @(posedge clk);
    map_en <= 1'b0;
    addr <= REG_ARL;
    wdata <= 16'h5555;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
    chk(refused, 1'b1);
    @(posedge clk);
    map_en <= 1'b1;
    cyc(0, REG_ARL, 16'h0000, 2'h3);
    chk(rdata[15:0], 16'h1238);
    @(posedge clk);
    addr <= REG_CR0H;
    wdata <= 16'h8000;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    power_down_instr <= 1'b1;
    @(posedge clk);
    power_down_instr <= 1'b0;
    @(posedge clk);
    #1;
    chk(refused, 1'b1);
    chk(powered, 1'b1);
    wait_for(0, 1'b0, OP_CYCLES + 8);
    $display("t_refuse done");
  endtask
  task automatic t_map();
    cyc(0, 24'h000038, 16'h0000, 2'h3);
    chk(rdata, 32'h12361234);
    cyc(0, 24'h010038, 16'h0000, 2'h3);
    chk(rdata, 32'h0);
    @(posedge clk);
    remap <= 1'b1;
    cyc(0, 24'h010038, 16'h0000, 2'h3);
    chk(rdata, 32'h12361234);
    cyc(0, 24'h008038, 16'h0000, 2'h3);
    chk(rdata, 32'h0);
    @(posedge clk);
    boot <= 1'b1;
    cyc(0, 24'h000038, 16'h0000, 2'h3);
    chk(rdata, 32'h12361234);
    cyc(2, 24'h000038, 16'h0000, 2'h3);
    chk(rdata, INVALID_WORD);
    @(posedge clk);
    remap <= 1'b0;
    @(posedge clk);
    remap <= 1'b1;
    cyc(0, 24'h010038, 16'h0000, 2'h3);
    chk(rdata, 32'h12361234);
    @(posedge clk);
    {boot, remap} <= 2'b00;
    $display("t_map done");
  endtask
  task automatic t_power_down_instr();
    @(posedge clk);
    power_down_instr <= 1'b1;
    @(posedge clk);
    power_down_instr <= 1'b0;
    wait_for(1, 1'b0, 8);
    wait_for(1, 1'b1, WAKE_CYCLES + 16);
    cyc(2, 24'h000000, 16'h0000, 2'h3);
    chk(trap, 1'b0);
    $display("t_power_down_instr done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_regs();
    t_ignore();
    t_op();
    t_supply();
    t_refuse();
    t_map();
    t_power_down_instr();
    end_sim();
  end
endmodule
